// >>> sim/ctdbg_top_assertions.sv
// Purpose: Port-level checks for ctdbg_top
// Assumes: One clock, asynchronous active-high reset
// Notes:   Shadows the cache control bits from observed writes
`timescale 1ns/1ps
module ctdbg_top_assertions
    import ctdbg_pkg::*;
(
    // Clock, reset, register port
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        cp_wr_in,
    input wire logic        cp_rd_in,
    input wire logic [3:0]  cp_sel_in,
    input wire logic [31:0] cp_wdata_in,
    input wire logic [31:0] cp_rdata_out,
    input wire logic        cp_rvalid_out,
    // Cache and TLB effects
    input wire logic [1:0]  d_attr_out,
    input wire logic        d_store_hit_in,
    input wire logic        d_mark_dirty_out,
    input wire logic        d_store_to_mem_out,
    input wire logic        d_force_clean_out,
    input wire logic        d_miss_in,
    input wire logic        d_fill_write_out,
    input wire logic        d_fill_forward_out,
    input wire logic [3:0]  fill_words_out,
    input wire logic        d_walk_done_in,
    input wire logic        d_main_store_out,
    input wire logic        d_walk_forward_out,
    input wire logic        main_load_off_data_out
);
    logic [2:0] cache_q;
    logic [2:0] cache_d;
    always_comb begin
        cache_d = cache_q;
        if (cp_wr_in && cp_sel_in == CTDBG_SEL_CACHE) begin
            cache_d = cp_wdata_in[2:0];
        end
    end
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cache_q <= CTDBG_CACHE_RST;
        end else begin
            cache_q <= cache_d;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    property p_rd_answer; cp_rd_in |=> cp_rvalid_out; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
    property p_idle; !cp_rd_in |=> !cp_rvalid_out && cp_rdata_out == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_fwt; cache_q[CTDBG_FWT_BIT] |-> d_attr_out != 2'h3; endproperty
    a_fwt: assert property (p_fwt) else $error("write-back while forced");
    property p_dirty; d_mark_dirty_out == (d_store_hit_in && d_attr_out == 2'h3); endproperty
    a_dirty: assert property (p_dirty) else $error("dirty marking wrong");
    property p_mem; d_store_hit_in && d_attr_out != 2'h3 |-> d_store_to_mem_out; endproperty
    a_mem: assert property (p_mem) else $error("store not sent to memory");
    property p_clean; $rose(cache_q[CTDBG_FWT_BIT]) |-> !d_force_clean_out [*3]; endproperty
    a_clean: assert property (p_clean) else $error("lines cleaned by force");
    property p_fill; d_miss_in |-> d_fill_forward_out
        && d_fill_write_out == !cache_q[CTDBG_DLF_BIT];
    endproperty
    a_fill: assert property (p_fill) else $error("data linefill wrong");
    property p_words; d_miss_in |-> fill_words_out == 4'h8; endproperty
    a_words: assert property (p_words) else $error("fill length wrong");
    property p_walk; d_walk_done_in |-> d_walk_forward_out
        && d_main_store_out == !main_load_off_data_out; endproperty
    a_walk: assert property (p_walk) else $error("walk result handling wrong");
endmodule : ctdbg_top_assertions

bind ctdbg_top ctdbg_top_assertions i_ctdbg_top_assertions (.core_clk_in, .rst_in, .cp_wr_in,
    .cp_rd_in, .cp_sel_in, .cp_wdata_in, .cp_rdata_out, .cp_rvalid_out, .d_attr_out,
    .d_store_hit_in, .d_mark_dirty_out, .d_store_to_mem_out, .d_force_clean_out, .d_miss_in,
    .d_fill_write_out, .d_fill_forward_out, .fill_words_out, .d_walk_done_in,
    .d_main_store_out, .d_walk_forward_out, .main_load_off_data_out);

// >>> sim/ctdbg_top_test.sv
// Purpose: Self-checking bench for ctdbg_top
// Assumes: Strobes one cycle wide, read answer one cycle later
// Notes:   Random register values with fixed corner sets first
`timescale 1ns/1ps
module ctdbg_top_test
    import ctdbg_pkg::*;
;
    logic        core_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        cp_wr_in = 1'b0;
    logic        cp_rd_in = 1'b0;
    logic [3:0]  cp_sel_in = 4'h0;
    logic [31:0] cp_wdata_in = 32'h0;
    logic        i_pt_c_in = 1'b0, i_pt_b_in = 1'b0, d_pt_c_in = 1'b0, d_pt_b_in = 1'b0;
    logic        d_store_hit_in = 1'b0, d_line_dirty_in = 1'b0, i_miss_in = 1'b0;
    logic        d_miss_in = 1'b0, i_walk_done_in = 1'b0, d_walk_done_in = 1'b0;
    logic [31:0] cp_rdata_out;
    logic [1:0]  i_attr_out, d_attr_out;
    logic [3:0]  fill_words_out;
    logic        cp_rvalid_out, d_mark_dirty_out, d_store_to_mem_out, d_force_clean_out;
    logic        i_fill_write_out, d_fill_write_out, i_fill_forward_out, d_fill_forward_out;
    logic        main_match_off_instr_out, main_match_off_data_out, main_load_off_instr_out;
    logic        main_load_off_data_out, imicro_match_off_out, dmicro_match_off_out;
    logic        imicro_load_off_out, dmicro_load_off_out, i_main_store_out, d_main_store_out;
    logic        i_walk_forward_out, d_walk_forward_out;
    logic [31:0] tags [8];
    logic [31:0] pas [8];
    int          bad_count = 0;
    int          samples_checked = 0;
    ctdbg_top i_ctdbg_top (.core_clk_in, .rst_in, .cp_wr_in, .cp_rd_in, .cp_sel_in,
        .cp_wdata_in, .cp_rdata_out, .cp_rvalid_out, .i_pt_c_in, .i_pt_b_in, .d_pt_c_in,
        .d_pt_b_in, .i_attr_out, .d_attr_out, .d_store_hit_in, .d_line_dirty_in,
        .d_mark_dirty_out, .d_store_to_mem_out, .d_force_clean_out, .i_miss_in, .d_miss_in,
        .i_fill_write_out, .d_fill_write_out, .i_fill_forward_out, .d_fill_forward_out,
        .fill_words_out, .i_walk_done_in, .d_walk_done_in, .main_match_off_instr_out,
        .main_match_off_data_out, .main_load_off_instr_out, .main_load_off_data_out,
        .imicro_match_off_out, .dmicro_match_off_out, .imicro_load_off_out,
        .dmicro_load_off_out, .i_main_store_out, .d_main_store_out, .i_walk_forward_out,
        .d_walk_forward_out);
    always #5 core_clk_in = ~core_clk_in;
    ////////////////////////////////////////
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_port(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD port %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_port
    task automatic wr(input logic [3:0] s, input logic [31:0] d);
        @(posedge core_clk_in);
        cp_wr_in <= 1'b1;
        cp_sel_in <= s;
        cp_wdata_in <= d;
        @(posedge core_clk_in);
        cp_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] s, input logic [31:0] exp, input string what);
        @(posedge core_clk_in);
        cp_rd_in <= 1'b1;
        cp_sel_in <= s;
        @(posedge core_clk_in);
        cp_rd_in <= 1'b0;
        #1;
        chk_port("rvalid", 32'h1, {31'h0, cp_rvalid_out});
        chk_word(what, exp, cp_rdata_out);
    endtask : rd
    task automatic do_reset();
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd(CTDBG_SEL_CACHE, 32'h0, "cache ctl");
        rd(CTDBG_SEL_TLB, 32'h0, "tlb ctl");
        rd(CTDBG_SEL_REMAP, 32'h0000e4e4, "remap");
        rd(CTDBG_SEL_TAG, 32'h0, "unwritten tag");
        rd(CTDBG_SEL_PA, 32'h0, "unwritten pa");
    endtask : do_reset
    function automatic logic [1:0] exp_attr(logic [7:0] m, logic c, logic b, logic f);
        logic [1:0] a;
        a = m[2 * {c, b} +: 2];
        if (f && a == 2'h3) a = 2'h2;
        return a;
    endfunction : exp_attr
    // Random sideband traffic against the programmed register set
    task automatic ports(input logic [15:0] m, input logic [2:0] k, input logic [7:0] t);
        logic [1:0] ea;
        repeat (16) begin
            @(posedge core_clk_in);
            {i_pt_c_in, i_pt_b_in, d_pt_c_in, d_pt_b_in, d_store_hit_in, d_line_dirty_in,
                i_miss_in, d_miss_in, i_walk_done_in, d_walk_done_in} <= 10'($urandom);
            #1;
            ea = exp_attr(m[7:0], d_pt_c_in, d_pt_b_in, k[2]);
            chk_port("i attr", 32'(exp_attr(m[15:8], i_pt_c_in, i_pt_b_in, 1'b0)),
                32'(i_attr_out));
            chk_port("d attr", 32'(ea), 32'(d_attr_out));
            chk_port("dirty", 32'(d_store_hit_in && ea == 2'h3), 32'(d_mark_dirty_out));
            chk_port("to mem", 32'(d_store_hit_in && ea != 2'h3), 32'(d_store_to_mem_out));
            chk_port("clean", 32'h0, 32'(d_force_clean_out));
            chk_port("fill", 32'({i_miss_in & ~k[1], d_miss_in & ~k[0], i_miss_in, d_miss_in,
                4'h8}), 32'({i_fill_write_out, d_fill_write_out, i_fill_forward_out,
                d_fill_forward_out, fill_words_out}));
            chk_port("tlb off", 32'(t), 32'({main_match_off_instr_out, main_match_off_data_out,
                main_load_off_instr_out, main_load_off_data_out, imicro_match_off_out,
                dmicro_match_off_out, imicro_load_off_out,
                dmicro_load_off_out}));
            chk_port("walk", 32'({i_walk_done_in & ~t[5], d_walk_done_in & ~t[4],
                i_walk_done_in, d_walk_done_in}), 32'({i_main_store_out, d_main_store_out,
                i_walk_forward_out, d_walk_forward_out}));
        end
    endtask : ports
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        logic [15:0] m;
        logic [2:0]  k;
        logic [7:0]  t;
        void'($urandom(32'h0c86d28b));
        do_reset();
        for (int s = 7; s < 16; s++) rd(4'(s), 32'h0, "unmapped");
        ports(16'he4e4, 3'h0, 8'h00);
        for (int n = 0; n < 8; n++) begin
            m = (n == 0) ? 16'hffff : (n == 1) ? 16'h1b1b : 16'($urandom);
            k = (n == 0) ? 3'h7 : (n == 1) ? 3'h0 : 3'($urandom);
            t = (n == 0) ? 8'hff : (n == 1) ? 8'h3f : 8'($urandom);
            wr(CTDBG_SEL_CACHE, {29'h0, k});
            wr(CTDBG_SEL_TLB, {24'h0, t});
            wr(CTDBG_SEL_REMAP, {16'h0, m});
            rd(CTDBG_SEL_CACHE, {29'h0, k}, "cache ctl");
            rd(CTDBG_SEL_TLB, {24'h0, t}, "tlb ctl");
            rd(CTDBG_SEL_REMAP, {16'h0, m}, "remap");
            ports(m, k, t);
        end
        for (int i = 0; i < 8; i++) begin
            tags[i] = $urandom;
            pas[i] = $urandom;
            wr(CTDBG_SEL_ENTRY, {3'h0, 3'(i), 26'h0});
            wr(CTDBG_SEL_TAG, tags[i]);
            wr(CTDBG_SEL_PA, pas[i]);
            wr(CTDBG_SEL_XFER, 32'h0);
        end
        for (int i = 7; i >= 0; i--) begin
            wr(CTDBG_SEL_ENTRY, {3'h0, 3'(i), 26'h0});
            rd(CTDBG_SEL_TAG, tags[i] & 32'hfffffc1f, "tag");
            rd(CTDBG_SEL_PA, pas[i] & 32'hfffffcff, "pa");
        end
        // Staging alone must not reach the entry
        wr(CTDBG_SEL_TAG, ~tags[0]);
        rd(CTDBG_SEL_TAG, tags[0] & 32'hfffffc1f, "staged tag");
        do_reset();
        conclude();
    end
endmodule : ctdbg_top_test

// >>> src/ctdbg_attr_resolve.sv
// Purpose: Resolve cacheable/bufferable attribute of one access side
// Assumes: Page table C/B come from the translation result
// Notes:   Combinational
`timescale 1ns/1ps
module ctdbg_attr_resolve
    import ctdbg_pkg::*;
(
    // Inputs
    input  wire logic [7:0] remap_in,
    input  wire logic       pt_c_in,
    input  wire logic       pt_b_in,
    input  wire logic       force_wt_in,
    // Result
    output ctdbg_attr_t     attr_out
);
    logic [1:0] region;
    ctdbg_attr_t remapped;

    always_comb begin
        region   = {pt_c_in, pt_b_in};
        remapped = ctdbg_attr_t'(remap_in[{region, 1'b0} +: 2]);
        // Forced write-through only touches cacheable results
        if (force_wt_in && remapped == CTDBG_ATTR_WB) begin
            attr_out = CTDBG_ATTR_WT;
        end else begin
            attr_out = remapped;
        end
    end
endmodule : ctdbg_attr_resolve

// >>> src/ctdbg_entry_ram.sv
// Purpose: Lockdown TLB entry storage
// Assumes: One write port, one asynchronous read port
// Notes:   Valid flags clear on reset so unwritten entries read as invalid
`timescale 1ns/1ps
module ctdbg_entry_ram
    import ctdbg_pkg::*;
#(
    parameter int unsigned ENTRIES = CTDBG_ENTRIES
) (
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_in,
    // Write
    input  wire logic                       wr_in,
    input  wire logic [$clog2(ENTRIES)-1:0] wr_idx_in,
    input  wire logic [31:0]                wr_tag_in,
    input  wire logic [31:0]                wr_pa_in,
    // Read
    input  wire logic [$clog2(ENTRIES)-1:0] rd_idx_in,
    output logic      [31:0]                rd_tag_out,
    output logic      [31:0]                rd_pa_out,
    output logic                            rd_written_out
);
    logic [31:0]        tag_q [ENTRIES];
    logic [31:0]        pa_q  [ENTRIES];
    logic [ENTRIES-1:0] wrt_q;
    logic [ENTRIES-1:0] wrt_d;

    always_comb begin
        wrt_d = wrt_q;
        if (wr_in) begin
            wrt_d[wr_idx_in] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wrt_q <= '0;
        end else begin
            wrt_q <= wrt_d;
        end
    end

    // Data array has no reset, it is plain RAM
    always_ff @(posedge core_clk_in) begin
        if (wr_in) begin
            tag_q[wr_idx_in] <= wr_tag_in;
            pa_q[wr_idx_in]  <= wr_pa_in;
        end
    end

    assign rd_tag_out     = tag_q[rd_idx_in];
    assign rd_pa_out      = pa_q[rd_idx_in];
    assign rd_written_out = wrt_q[rd_idx_in];
endmodule : ctdbg_entry_ram

// >>> src/ctdbg_pkg.sv
// Purpose: Constants for the cache and TLB debug control block
// Assumes: Coprocessor register transfers arrive as one-cycle strobes
// Notes:   Selector encoding is local to this block
// Function
// - Entry-select write takes bits 28:26 as lockdown entry index.
// - Entry reads valid only after write; tag and PA read separately.
// - Cache debug control resets to zero: write-back, linefills on.
// - Force write-through bit 2 overrides page table and remap.
// - Forcing write-through never cleans existing dirty lines.
// - Forced write-through store to clean line leaves it clean.
// - Forced store to dirty line updates cache and memory both.
// - Linefill disable bits still fetch eight words, no cache write.
// - Hits still return cache data; misses return memory words.
// - TLB debug control resets to zero, all matching and loading on.
// - Main TLB load off: walk still done, result forwarded around.
// - Bits 7 and 6 disable main TLB matching instruction and data.
// - Bits 3 and 2 disable instruction and data micro TLB matching.
// - Bits 1 and 0 disable instruction and data micro TLB loading.
// - Remap overrides page table and MMU-off default attributes.
// - Instruction remap fields in 15:8, reset 11,10,01,00.
// - Data remap fields in 7:0 same order; upper bits read zero.
// - Field code: 00 NCNB, 01 NCB, 10 write-through, 11 write-back.
// - Tag word: address 31:10, valid bit 4, size code 3:0.
// - PA word: address 31:10, domain 7:4, permission 3:2, C, B.
package ctdbg_pkg;
    // Register selectors on the coprocessor port
    typedef enum logic [3:0] {
        CTDBG_SEL_ENTRY   = 4'h0,
        CTDBG_SEL_TAG     = 4'h1,
        CTDBG_SEL_PA      = 4'h2,
        CTDBG_SEL_XFER    = 4'h3,
        CTDBG_SEL_CACHE   = 4'h4,
        CTDBG_SEL_TLB     = 4'h5,
        CTDBG_SEL_REMAP   = 4'h6
    } ctdbg_sel_t;

    localparam int unsigned CTDBG_IDX_HI     = 28;
    localparam int unsigned CTDBG_IDX_LO     = 26;
    localparam int unsigned CTDBG_ENTRIES    = 8;
    localparam int unsigned CTDBG_ADDR_LO    = 10;
    localparam int unsigned CTDBG_VALID_BIT  = 4;
    localparam int unsigned CTDBG_FILL_WORDS = 8;

    // Cache debug control
    localparam int unsigned CTDBG_FWT_BIT = 2;
    localparam int unsigned CTDBG_ILF_BIT = 1;
    localparam int unsigned CTDBG_DLF_BIT = 0;
    localparam logic [2:0]  CTDBG_CACHE_RST = 3'h0;

    // TLB debug control
    localparam int unsigned CTDBG_MMI_BIT = 7;
    localparam int unsigned CTDBG_MMD_BIT = 6;
    localparam int unsigned CTDBG_MLI_BIT = 5;
    localparam int unsigned CTDBG_MLD_BIT = 4;
    localparam int unsigned CTDBG_UMI_BIT = 3;
    localparam int unsigned CTDBG_UMD_BIT = 2;
    localparam int unsigned CTDBG_ULI_BIT = 1;
    localparam int unsigned CTDBG_ULD_BIT = 0;
    localparam logic [7:0]  CTDBG_TLB_RST = 8'h00;

    // Remap: instruction half 15:8, data half 7:0
    localparam int unsigned CTDBG_REMAP_I_LO = 8;
    localparam int unsigned CTDBG_REMAP_D_LO = 0;
    localparam logic [15:0] CTDBG_REMAP_RST  = 16'he4e4;

    typedef enum logic [1:0] {
        CTDBG_ATTR_NCNB = 2'h0,
        CTDBG_ATTR_NCB  = 2'h1,
        CTDBG_ATTR_WT   = 2'h2,
        CTDBG_ATTR_WB   = 2'h3
    } ctdbg_attr_t;
endpackage : ctdbg_pkg

// >>> src/ctdbg_top.sv
// Purpose: Cache and TLB test/debug control registers and their effects
// Assumes: Coprocessor port gives one-cycle write/read strobes and a selector
// Notes:   Read data registered, valid one cycle after the read strobe
`timescale 1ns/1ps
module ctdbg_top
    import ctdbg_pkg::*;
#(
    parameter int unsigned ENTRIES    = CTDBG_ENTRIES,
    parameter int unsigned FILL_WORDS = CTDBG_FILL_WORDS
) (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // Coprocessor register transfer port
    input  wire logic        cp_wr_in,
    input  wire logic        cp_rd_in,
    input  wire logic [3:0]  cp_sel_in,
    input  wire logic [31:0] cp_wdata_in,
    output logic      [31:0] cp_rdata_out,
    output logic             cp_rvalid_out,
    // Attribute resolution, instruction and data side
    input  wire logic        i_pt_c_in,
    input  wire logic        i_pt_b_in,
    input  wire logic        d_pt_c_in,
    input  wire logic        d_pt_b_in,
    output logic      [1:0]  i_attr_out,
    output logic      [1:0]  d_attr_out,
    // Cache store hints
    input  wire logic        d_store_hit_in,
    input  wire logic        d_line_dirty_in,
    output logic             d_mark_dirty_out,
    output logic             d_store_to_mem_out,
    output logic             d_force_clean_out,
    // Cache miss handling
    input  wire logic        i_miss_in,
    input  wire logic        d_miss_in,
    output logic             i_fill_write_out,
    output logic             d_fill_write_out,
    output logic             i_fill_forward_out,
    output logic             d_fill_forward_out,
    output logic      [3:0]  fill_words_out,
    // TLB controls
    input  wire logic        i_walk_done_in,
    input  wire logic        d_walk_done_in,
    output logic             main_match_off_instr_out,
    output logic             main_match_off_data_out,
    output logic             main_load_off_instr_out,
    output logic             main_load_off_data_out,
    output logic             imicro_match_off_out,
    output logic             dmicro_match_off_out,
    output logic             imicro_load_off_out,
    output logic             dmicro_load_off_out,
    output logic             i_main_store_out,
    output logic             d_main_store_out,
    output logic             i_walk_forward_out,
    output logic             d_walk_forward_out
);
    localparam int unsigned IW = $clog2(ENTRIES);

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [IW-1:0] entry_idx_q, entry_idx_d;
    logic [31:0]   tag_stage_q, tag_stage_d;
    logic [31:0]   pa_stage_q,  pa_stage_d;
    logic [2:0]    cache_ctl_q, cache_ctl_d;
    logic [7:0]    tlb_ctl_q,   tlb_ctl_d;
    logic [15:0]   remap_q,     remap_d;
    logic [31:0]   rdata_q,     rdata_d;
    logic          rvalid_q,    rvalid_d;

    logic          xfer;
    logic [31:0]   ram_tag;
    logic [31:0]   ram_pa;
    logic          ram_written;

    function automatic logic is_sel(input logic [3:0] sel, input ctdbg_sel_t want);
        is_sel = (sel == want);
    endfunction : is_sel

    // Keep only the documented fields of an entry word
    function automatic logic [31:0] tag_word(input logic [31:0] w);
        tag_word = {w[31:CTDBG_ADDR_LO], 5'h00, w[CTDBG_VALID_BIT], w[3:0]};
    endfunction : tag_word

    function automatic logic [31:0] pa_word(input logic [31:0] w);
        pa_word = {w[31:CTDBG_ADDR_LO], 2'h0, w[7:0]};
    endfunction : pa_word

    assign xfer = cp_wr_in && is_sel(cp_sel_in, CTDBG_SEL_XFER);

    always_comb begin
        entry_idx_d = entry_idx_q;
        tag_stage_d = tag_stage_q;
        pa_stage_d  = pa_stage_q;
        cache_ctl_d = cache_ctl_q;
        tlb_ctl_d   = tlb_ctl_q;
        remap_d     = remap_q;
        if (cp_wr_in) begin
            case (cp_sel_in)
                CTDBG_SEL_ENTRY: begin
                    entry_idx_d = IW'(cp_wdata_in[CTDBG_IDX_HI:CTDBG_IDX_LO]);
                end
                CTDBG_SEL_TAG: begin
                    tag_stage_d = tag_word(cp_wdata_in);
                end
                CTDBG_SEL_PA: begin
                    pa_stage_d = pa_word(cp_wdata_in);
                end
                CTDBG_SEL_CACHE: begin
                    cache_ctl_d = cp_wdata_in[2:0];
                end
                CTDBG_SEL_TLB: begin
                    tlb_ctl_d = cp_wdata_in[7:0];
                end
                CTDBG_SEL_REMAP: begin
                    remap_d = cp_wdata_in[15:0];
                end
                default: begin
                    entry_idx_d = entry_idx_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb begin
        rvalid_d = cp_rd_in;
        rdata_d  = 32'h0000_0000;
        if (cp_rd_in) begin
            case (cp_sel_in)
                // Unwritten entry reads as zero, never stale RAM content
                CTDBG_SEL_TAG: begin
                    rdata_d = ram_written ? ram_tag : 32'h0000_0000;
                end
                CTDBG_SEL_PA: begin
                    rdata_d = ram_written ? ram_pa : 32'h0000_0000;
                end
                CTDBG_SEL_CACHE: begin
                    rdata_d = {29'h0, cache_ctl_q};
                end
                CTDBG_SEL_TLB: begin
                    rdata_d = {24'h0, tlb_ctl_q};
                end
                CTDBG_SEL_REMAP: begin
                    rdata_d = {16'h0000, remap_q};
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            entry_idx_q <= '0;
            tag_stage_q <= 32'h0000_0000;
            pa_stage_q  <= 32'h0000_0000;
            cache_ctl_q <= CTDBG_CACHE_RST;
            tlb_ctl_q   <= CTDBG_TLB_RST;
            remap_q     <= CTDBG_REMAP_RST;
            rdata_q     <= 32'h0000_0000;
            rvalid_q    <= 1'b0;
        end else begin
            entry_idx_q <= entry_idx_d;
            tag_stage_q <= tag_stage_d;
            pa_stage_q  <= pa_stage_d;
            cache_ctl_q <= cache_ctl_d;
            tlb_ctl_q   <= tlb_ctl_d;
            remap_q     <= remap_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
        end
    end

    assign cp_rdata_out  = rdata_q;
    assign cp_rvalid_out = rvalid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Lockdown entry storage

    ctdbg_entry_ram #(
        .ENTRIES        (ENTRIES)
    ) u_ram (
        .core_clk_in    (core_clk_in),
        .rst_in         (rst_in),
        .wr_in          (xfer),
        .wr_idx_in      (entry_idx_q),
        .wr_tag_in      (tag_stage_q),
        .wr_pa_in       (pa_stage_q),
        .rd_idx_in      (entry_idx_q),
        .rd_tag_out     (ram_tag),
        .rd_pa_out      (ram_pa),
        .rd_written_out (ram_written)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Attribute resolution

    logic        force_wt;
    ctdbg_attr_t i_attr;
    ctdbg_attr_t d_attr;

    assign force_wt = cache_ctl_q[CTDBG_FWT_BIT];

    // Instruction side is read-only, forcing write-through does not apply
    ctdbg_attr_resolve u_iattr (
        .remap_in    (remap_q[CTDBG_REMAP_I_LO +: 8]),
        .pt_c_in     (i_pt_c_in),
        .pt_b_in     (i_pt_b_in),
        .force_wt_in (1'b0),
        .attr_out    (i_attr)
    );

    ctdbg_attr_resolve u_dattr (
        .remap_in    (remap_q[CTDBG_REMAP_D_LO +: 8]),
        .pt_c_in     (d_pt_c_in),
        .pt_b_in     (d_pt_b_in),
        .force_wt_in (force_wt),
        .attr_out    (d_attr)
    );

    assign i_attr_out = i_attr;
    assign d_attr_out = d_attr;

    ////////////////////////////////////////////////////////////////////////////
    // Store and linefill hints

    // Under forced write-through clean lines stay clean; dirty lines keep other words dirty
    assign d_mark_dirty_out   = d_store_hit_in && !force_wt && d_attr == CTDBG_ATTR_WB;
    assign d_store_to_mem_out = d_store_hit_in && (force_wt || d_attr != CTDBG_ATTR_WB);
    // No clean is issued when forcing starts; dirty lines drain on eviction
    assign d_force_clean_out  = 1'b0;

    // Fill still runs so the core sees memory, only the cache write is gated
    assign i_fill_write_out   = i_miss_in && !cache_ctl_q[CTDBG_ILF_BIT];
    assign d_fill_write_out   = d_miss_in && !cache_ctl_q[CTDBG_DLF_BIT];
    assign i_fill_forward_out = i_miss_in;
    assign d_fill_forward_out = d_miss_in;
    assign fill_words_out     = 4'(FILL_WORDS);

    ////////////////////////////////////////////////////////////////////////////
    // TLB debug controls

    assign main_match_off_instr_out = tlb_ctl_q[CTDBG_MMI_BIT];
    assign main_match_off_data_out  = tlb_ctl_q[CTDBG_MMD_BIT];
    assign main_load_off_instr_out  = tlb_ctl_q[CTDBG_MLI_BIT];
    assign main_load_off_data_out   = tlb_ctl_q[CTDBG_MLD_BIT];
    assign imicro_match_off_out     = tlb_ctl_q[CTDBG_UMI_BIT];
    assign dmicro_match_off_out     = tlb_ctl_q[CTDBG_UMD_BIT];
    assign imicro_load_off_out      = tlb_ctl_q[CTDBG_ULI_BIT];
    assign dmicro_load_off_out      = tlb_ctl_q[CTDBG_ULD_BIT];

    // Walk result always reaches the core; storing it is optional
    assign i_main_store_out   = i_walk_done_in && !tlb_ctl_q[CTDBG_MLI_BIT];
    assign d_main_store_out   = d_walk_done_in && !tlb_ctl_q[CTDBG_MLD_BIT];
    assign i_walk_forward_out = i_walk_done_in;
    assign d_walk_forward_out = d_walk_done_in;
endmodule : ctdbg_top
